// >>> src/srpg_ctrl.sv
/*
 * SYSREF pulse generator control. Holds the launch sequencing, counted and
 * continuous modes, external trigger arming, alignment and delay loading.
 * Assumes the serial register interface presents the stored fields on cfg
 * and a one-cycle launch_wr pulse when software writes the launch bit as 1,
 * all on clk_sys. The external trigger pin is asynchronous.
 */
`timescale 1ns/1ps
module srpg_ctrl
    import srpg_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire srpg_cfg_t    cfg,
    input  wire logic         launch_wr,
    input  wire logic         external_trigger_pin,
    output logic              sysref_outputs,
    output logic              sysref_power_up,
    output logic              sysref_align,
    output logic [7:0]        sysref_delay_loaded,
    output srpg_status_t      status
);

    // Trigger pin synchroniser and edge history
    logic        trig_meta_ff;
    logic        trig_sync_ff;
    logic        trig_prev_ff;
    logic        trig_rise;

    // Control state
    srpg_state_t state_ff;
    srpg_state_t nxt_state;
    logic [7:0]  left_ff;
    logic [7:0]  nxt_left;
    logic        pending_ff;
    logic        nxt_pending;
    logic        pulse_ff;
    logic        nxt_pulse;
    logic        power_ff;
    logic        nxt_power;
    logic        align_ff;
    logic        nxt_align;
    logic [7:0]  delay_ff;
    logic [7:0]  nxt_delay;
    logic        cont_ff;
    logic        nxt_cont;
    logic [6:0]  divcfg_ff;
    logic        cfg_changed;
    srpg_status_t status_ff;
    srpg_status_t nxt_status;

    logic        rel_tick;
    logic        start;

    srpg_release_div u_release_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .div_cfg (cfg.sysref_release_divider_cfg),
        .align   (align_ff),
        .tick    (rel_tick),
        .ratio   ()
    );

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trig_meta_ff <= 1'b0;
            trig_sync_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
        end else begin
            trig_meta_ff <= external_trigger_pin;
            trig_sync_ff <= trig_meta_ff;
            trig_prev_ff <= trig_sync_ff;
        end
    end

    assign trig_rise   = trig_sync_ff & ~trig_prev_ff;
    // Changing the divider stops a continuous run so pulses never straddle ratios
    assign cfg_changed = (divcfg_ff != cfg.sysref_release_divider_cfg);

    always_comb begin
        nxt_state   = state_ff;
        nxt_left    = left_ff;
        nxt_pulse   = 1'b0;
        nxt_power   = power_ff;
        nxt_align   = 1'b0;
        nxt_delay   = delay_ff;
        nxt_cont    = cont_ff;
        nxt_pending = pending_ff;
        start       = 1'b0;

        if (launch_wr) begin
            nxt_power   = 1'b1;
            nxt_delay   = cfg.global_sysref_phase_delay;
            nxt_cont    = cfg.sysref_continuous_mode;
            nxt_left    = cfg.sysref_pulse_count;
            nxt_pending = 1'b1;
            if (cfg.sysref_trigger_source) begin
                nxt_state = SRPG_ARMED;
            end else begin
                // Immediate launch aligns at once and starts the run, no pin edge needed
                nxt_align = 1'b1;
                start     = 1'b1;
            end
        end

        case (state_ff)
            SRPG_IDLE: begin
                if (start) begin
                    nxt_state = SRPG_RUN;
                end
            end
            SRPG_ARMED: begin
                if (start) begin
                    nxt_state = SRPG_RUN;
                end else if (!launch_wr && trig_rise) begin
                    nxt_state = SRPG_RUN;
                    nxt_align = 1'b1;
                end
            end
            SRPG_RUN: begin
                if (launch_wr) begin
                    // Relaunch restarts from full count, or re-arms when external
                    nxt_state = cfg.sysref_trigger_source ? SRPG_ARMED : SRPG_RUN;
                end else if (cont_ff) begin
                    if (!cfg.sysref_continuous_mode || cfg_changed) begin
                        nxt_state   = SRPG_IDLE;
                        nxt_pending = 1'b0;
                    end else if (rel_tick) begin
                        nxt_pulse = 1'b1;
                    end
                end else if (left_ff == 8'h00) begin
                    nxt_state   = SRPG_IDLE;
                    nxt_pending = launch_wr;
                end else if (rel_tick) begin
                    nxt_pulse = 1'b1;
                    nxt_left  = left_ff - 8'h01;
                    if (left_ff == 8'h01) begin
                        nxt_state   = SRPG_IDLE;
                        nxt_pending = launch_wr;
                    end
                end
            end
            default: begin
                nxt_state = SRPG_IDLE;
            end
        endcase

        nxt_status.sysref_launch_pending = nxt_pending;
        nxt_status.sysref_armed          = (nxt_state == SRPG_ARMED);
        nxt_status.sysref_running        = (nxt_state == SRPG_RUN);
        nxt_status.pulses_left           = nxt_left;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff   <= SRPG_IDLE;
            left_ff    <= PULSE_CNT_RESET;
            pulse_ff   <= 1'b0;
            power_ff   <= 1'b0;
            align_ff   <= 1'b0;
            delay_ff   <= PHASE_DLY_RESET;
            cont_ff    <= CONT_MODE_RESET;
            pending_ff <= 1'b0;
            divcfg_ff  <= REL_DIV_RESET;
            status_ff  <= '0;
        end else begin
            state_ff   <= nxt_state;
            left_ff    <= nxt_left;
            pulse_ff   <= nxt_pulse;
            power_ff   <= nxt_power;
            align_ff   <= nxt_align;
            delay_ff   <= nxt_delay;
            cont_ff    <= nxt_cont;
            pending_ff <= nxt_pending;
            divcfg_ff  <= cfg.sysref_release_divider_cfg;
            status_ff  <= nxt_status;
        end
    end

    assign sysref_outputs      = pulse_ff;
    assign sysref_power_up     = power_ff;
    assign sysref_align        = align_ff;
    assign sysref_delay_loaded = delay_ff;
    assign status              = status_ff;

endmodule : srpg_ctrl

// >>> src/srpg_pkg.sv
/*
 * Package of the SYSREF pulse generator control: register field layouts,
 * reset values, release-divider factor tables, delay step, state encoding
 * and the configuration and status carriers.
 * Assumes one clock (the synthesized output clock) and a serial register
 * interface outside this block that presents the register fields as levels.
 */
package srpg_pkg;

    // Release divider configuration field layout
    localparam int REL_CASCADE_BIT = 6;
    localparam int REL_UPPER_MSB   = 5;
    localparam int REL_UPPER_LSB   = 3;
    localparam int REL_LOWER_MSB   = 2;
    localparam int REL_LOWER_LSB   = 0;

    // Reset values of the register fields
    localparam logic [6:0] REL_DIV_RESET    = 7'h01;
    localparam logic [7:0] PULSE_CNT_RESET  = 8'h02;
    localparam logic [7:0] PHASE_DLY_RESET  = 8'h00;
    localparam logic       TRIG_SRC_RESET   = 1'b0;
    localparam logic       CONT_MODE_RESET  = 1'b0;

    // Single-stage factor is the code plus this offset (2..9)
    localparam logic [7:0] LOWER_FACTOR_BASE = 8'h02;

    // Upper stage factors of the cascaded release divider, indexed by code
    localparam logic [7:0] UPPER_FACTOR [8] = '{
        8'h02, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h10, 8'h10
    };

    // Global SYSREF delay step; the analog line applies it, this block loads it
    localparam int DELAY_STEP_PS  = 339;
    localparam int DELAY_STEPS    = 256;

    // Release counter step, also the end-of-ratio offset
    localparam logic [7:0] RATIO_ONE = 8'h01;

    typedef enum logic [1:0] {
        SRPG_IDLE  = 2'b00,
        SRPG_ARMED = 2'b01,
        SRPG_RUN   = 2'b10
    } srpg_state_t;

    typedef struct packed {
        logic [6:0] sysref_release_divider_cfg;
        logic [7:0] sysref_pulse_count;
        logic [7:0] global_sysref_phase_delay;
        logic       sysref_trigger_source;
        logic       sysref_continuous_mode;
    } srpg_cfg_t;

    typedef struct packed {
        logic       sysref_launch_pending;
        logic       sysref_armed;
        logic       sysref_running;
        logic [7:0] pulses_left;
    } srpg_status_t;

endpackage : srpg_pkg

// >>> src/srpg_release_div.sv
/*
 * Release divider of the SYSREF pulse generator: decodes the seven-bit
 * configuration into a ratio and ticks once per ratio cycles.
 * Assumes the caller pulses align on launch so that ticks line up with the
 * device-clock dividers, which are restarted by the same event outside.
 */
`timescale 1ns/1ps
module srpg_release_div
    import srpg_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [6:0] div_cfg,
    input  wire logic       align,
    output logic            tick,
    output logic [7:0]      ratio
);

    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       tick_ff;
    logic       nxt_tick;
    logic [7:0] lower_f;
    logic [7:0] dec_ratio;
    logic [15:0] prod;

    always_comb begin
        lower_f   = LOWER_FACTOR_BASE + {5'h00, div_cfg[REL_LOWER_MSB:REL_LOWER_LSB]};
        prod      = UPPER_FACTOR[div_cfg[REL_UPPER_MSB:REL_UPPER_LSB]] * lower_f;
        if (div_cfg[REL_CASCADE_BIT]) begin
            dec_ratio = prod[7:0];
        end else begin
            dec_ratio = lower_f;
        end
    end

    always_comb begin
        nxt_tick = 1'b0;
        if (align) begin
            nxt_cnt = 8'h00;
        end else if (cnt_ff >= dec_ratio - RATIO_ONE) begin
            nxt_cnt  = 8'h00;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + RATIO_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // A tick counted before the alignment is stale and would release early
    assign tick  = tick_ff & ~align;
    assign ratio = dec_ratio;

endmodule : srpg_release_div

// >>> verif/srpg_ctrl_properties.sv
/* Port checker for srpg_ctrl, bound to every instance.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module srpg_ctrl_properties
    import srpg_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst,
    input wire srpg_cfg_t    cfg,
    input wire logic         launch_wr,
    input wire logic         external_trigger_pin,
    input wire logic         sysref_outputs,
    input wire logic         sysref_power_up,
    input wire logic         sysref_align,
    input wire logic [7:0]   sysref_delay_loaded,
    input wire srpg_status_t status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    launch_align_a: assert property (launch_wr && !cfg.sysref_trigger_source |=>
        sysref_align)
        else $error("align missing after launch");
    delay_load_a: assert property (launch_wr |=>
        sysref_delay_loaded == $past(cfg.global_sysref_phase_delay))
        else $error("delay not loaded at launch");
    delay_hold_a: assert property (!launch_wr |=> $stable(sysref_delay_loaded))
        else $error("delay changed without launch");
    power_on_a: assert property (launch_wr |=> sysref_power_up[*3])
        else $error("power up not held after launch");
    ext_arm_a: assert property (launch_wr && cfg.sysref_trigger_source |=>
        !sysref_align && !sysref_outputs)
        else $error("external launch did not only arm");
    pulse_gap_a: assert property (sysref_outputs |=> !sysref_outputs)
        else $error("pulses closer than two cycles");
    first_pulse_a: assert property (sysref_align && cfg.sysref_pulse_count != 8'h00 |->
        ##[2:200] sysref_outputs)
        else $error("no pulse after align");
    keep_going_a: assert property (sysref_outputs && cfg.sysref_continuous_mode |->
        ##[1:150] (sysref_outputs || !cfg.sysref_continuous_mode))
        else $error("continuous pulses stopped");
    self_clear_a: assert property ($fell(status.sysref_running) &&
        !cfg.sysref_continuous_mode |-> !status.sysref_launch_pending)
        else $error("launch pending after counted burst");

    cover property (launch_wr && !cfg.sysref_continuous_mode);
    cover property (launch_wr && cfg.sysref_trigger_source);
    cover property (sysref_outputs && cfg.sysref_continuous_mode);
endmodule : srpg_ctrl_properties

bind srpg_ctrl srpg_ctrl_properties u_props (.clk_sys(clk_sys), .rst(rst), .cfg(cfg),
    .launch_wr(launch_wr), .external_trigger_pin(external_trigger_pin),
    .sysref_outputs(sysref_outputs), .sysref_power_up(sysref_power_up),
    .sysref_align(sysref_align), .sysref_delay_loaded(sysref_delay_loaded), .status(status));

// >>> verif/srpg_ctrl_test.sv
/* Self-checking bench of srpg_ctrl with a reference pulse model.
   Assumes the register fields reach the block as levels on cfg. */
`timescale 1ns/1ps
module srpg_ctrl_test;
    import srpg_pkg::*;
    logic         clk_sys, rst, launch_wr, sysref_outputs, sysref_power_up, sysref_align, pin;
    logic [7:0]   sysref_delay_loaded;
    srpg_cfg_t    cfg;
    srpg_status_t status;
    int           failures, checks_done, seed, r, n;
    int           up_f [8] = '{2, 4, 6, 8, 12, 16, 16, 16};

    srpg_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .launch_wr(launch_wr),
        .external_trigger_pin(pin), .sysref_outputs(sysref_outputs),
        .sysref_power_up(sysref_power_up), .sysref_align(sysref_align),
        .sysref_delay_loaded(sysref_delay_loaded), .status(status));
    srpg_partner u_partner (.clk_sys(clk_sys), .external_trigger_pin(pin));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    function automatic int ratio_of(logic [6:0] d);
        return d[6] ? up_f[d[5:3]] * (int'(d[2:0]) + 2) : int'(d[2:0]) + 2;
    endfunction : ratio_of

    // Counts pulses; ext >= 0 fires the trigger at that cycle
    task automatic count_in(int cyc, int rt, int ext, output int seen);
        int gap;
        seen = 0;
        gap = 0;
        for (int i = 0; i < cyc; i++) begin
            if (i == ext) begin
                check("armed", seen, 0);
                fork u_partner.fire(3); join_none
            end
            @(negedge clk_sys);
            gap++;
            if (sysref_outputs) begin
                if (seen > 0) check("gap", gap, rt);
                seen++;
                gap = 0;
            end
        end
    endtask : count_in

    task automatic burst(logic [6:0] d, logic [7:0] cnt, logic [7:0] dly, logic src,
                         logic cont, int ext, int exp_n, int lw);
        int seen;
        cfg = '{d, cnt, dly, src, cont};
        launch_wr = 1'b1;
        repeat (lw) @(negedge clk_sys);
        launch_wr = 1'b0;
        check("delay", sysref_delay_loaded, dly);
        check("power", sysref_power_up, 1'b1);
        check("align", sysref_align, !src);
        check("armed", status.sysref_armed, src);
        count_in(ratio_of(d) * (exp_n + 3) + ext + 10, ratio_of(d), ext, seen);
        if (exp_n >= 0) check("count", seen, exp_n);
        if (exp_n >= 0) check("self clear", status.sysref_launch_pending, 1'b0);
    endtask : burst

    initial begin
        seed = 32'h5f04;
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        launch_wr = 1'b0;
        cfg = '{REL_DIV_RESET, PULSE_CNT_RESET, PHASE_DLY_RESET, TRIG_SRC_RESET, CONT_MODE_RESET};
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        check("reset", {sysref_power_up, sysref_delay_loaded, status}, 0);
        burst(7'h00, 8'h02, 8'h00, 1'b0, 1'b0, -1, 2, 1);
        burst(7'h07, 8'hff, 8'hff, 1'b0, 1'b0, -1, 255, 1);
        burst(7'h02, 8'h03, 8'h5a, 1'b0, 1'b0, -1, 3, 2);
        burst(7'h00, 8'h00, 8'h01, 1'b0, 1'b0, -1, 0, 1);
        for (int k = 0; k < 6; k++) begin
            r = $random(seed);
            n = 1 + int'(r[11:10]);
            // Cascade only with larger factor low, so no shorter encoding exists
            burst(r[8] ? {1'b1, 2'b00, r[0], 2'b11, r[1]} : {4'h0, r[2:0]},
                  8'(n), r[23:16], 1'b0, 1'b0, -1, n, 1);
        end
        burst(7'h01, 8'h04, 8'h11, 1'b1, 1'b0, 30, 4, 1);
        burst(7'h00, 8'h02, 8'h22, 1'b0, 1'b1, -1, -1, 1);
        count_in(20, 2, -1, n);
        check("continuous", n, 10);
        cfg.sysref_continuous_mode = 1'b0;
        repeat (6) @(negedge clk_sys);
        count_in(20, 2, -1, n);
        check("stopped", n, 0);
        close_out();
    end
endmodule : srpg_ctrl_test

// >>> verif/srpg_partner.sv
/* Far-side model: the converter board that drives the trigger pin.
   Assumes the bench calls fire from a falling clock edge. */
`timescale 1ns/1ps
module srpg_partner (
    input  wire logic clk_sys,
    output logic      external_trigger_pin
);
    initial external_trigger_pin = 1'b0;

    // Hold length sets how many falling clock edges the pin stays high; the bench always uses 3
    task fire(input int hold);
        external_trigger_pin = 1'b1;
        repeat (hold) @(negedge clk_sys);
        external_trigger_pin = 1'b0;
    endtask : fire
endmodule : srpg_partner
